/* File: hw/dcf_pkg.sv */
// constants for the control function register bank
package dcf_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          RATE_W          = 16;
    localparam logic [7:0]  CTRL_ADDR       = 8'h00;
    localparam logic [7:0]  RATE_ADDR       = 8'h08;
    localparam logic [7:0]  STATUS_ADDR     = 8'h09;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
    localparam logic [15:0] RATE_RESET      = 16'h0000;
    localparam int          MODULUS_BIT     = 28;
    localparam int          DIRECT_BIT      = 16;
    localparam int          DEST_HI         = 13;
    localparam int          DEST_LO         = 12;
    localparam int          AUX_EN_BIT      = 11;
    localparam int          DC_OUT_BIT      = 10;
    localparam int          TRIG_BIT        = 9;
    localparam int          NO_DWELL_BIT    = 8;
    localparam int          EXT_PD_MODE_BIT = 7;
    localparam int          DIG_PD_BIT      = 6;
    localparam int          DAC_PD_BIT      = 5;
    localparam int          CLK_PD_BIT      = 4;
    localparam int          RATE_RELOAD_BIT = 3;
    localparam int          AUX_CLR_BIT     = 2;
    localparam int          PHASE_CLR_BIT   = 1;
    localparam int          SINE_BIT        = 0;
    localparam logic [1:0]  DEST_FREQ       = 2'h0;
    localparam logic [1:0]  DEST_PHASE      = 2'h1;
endpackage

/* File: hw/dcf_rate_timer.sv */
// ramp rate timer with deferred or immediate reload of the rate value
`timescale 1ns/10ps
`default_nettype none
module dcf_rate_timer
(
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    input  wire logic                      runEnable,
    input  wire logic [dcf_pkg::RATE_W-1:0] rateValue,
    input  wire logic                      rateLoadNow,
    output logic                           timerTick,
    output logic                           timerRunning
);
    logic [dcf_pkg::RATE_W-1:0] count;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count <= dcf_pkg::RATE_RESET;
        end
        else if (!runEnable)
        begin
            count <= rateValue;
        end
        else if (rateLoadNow)
        begin
            // abort the running count and restart from the new rate
            count <= rateValue;
        end
        else if (count == '0)
        begin
            // without an immediate reload a new rate takes over at expiry
            count <= rateValue;
        end
        else
        begin
            count <= count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            timerTick    <= 1'b0;
            timerRunning <= 1'b0;
        end
        else
        begin
            timerTick    <= runEnable && !rateLoadNow && (count == '0);
            timerRunning <= runEnable;
        end
    end
endmodule
`default_nettype wire

/* File: hw/dcf_control.sv */
// first control function register: shadow, update transfer and decoded controls
`timescale 1ns/10ps
`default_nettype none
// How it works
// - destination zero routes aux accumulator to frequency
// - destination one gives phase keying or sweep
// - enable bit activates aux accumulator, and sweep unless modulus or direct switch bit set
// - dc bit forces full scale during sweep
// - trigger bit picks edge or level sweep
// - no-dwell bit returns sweep to start
// - fast power-down stops only digital logic
// - full power-down stops everything including pll
// - digital power-down bit idles the core
// - converter power-down bit idles the converter
// - clock power-down bit stops all clocks
// - rate waits for timer expiry when bit clear
// - rate reloads at update when bit set
// - update clears aux accumulator one cycle when bit set
// - update clears phase accumulator one cycle when bit set
// - sine bit picks sine, else cosine
// - written values act only at update strobe
// - direct switch bit enables keying mode
// - modulus bit redirects aux accumulator
module dcf_control
(
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    input  wire logic                       hostWrite,
    input  wire logic [dcf_pkg::ADDR_W-1:0] hostAddr,
    input  wire logic [dcf_pkg::DATA_W-1:0] hostWriteData,
    output logic      [dcf_pkg::DATA_W-1:0] hostReadData,
    input  wire logic                       ioUpdatePin,
    input  wire logic                       powerDownPin,
    output logic                            freqSweep,
    output logic                            phaseSweep,
    output logic                            freqKeying,
    output logic                            phaseKeying,
    output logic                            modulusActive,
    output logic                            auxAccActive,
    output logic                            dcOutputForce,
    output logic                            waveformEnable,
    output logic                            sweepLevelTrigger,
    output logic                            sweepNoDwell,
    output logic                            digitalPowerDown,
    output logic                            dacDigitalPowerDown,
    output logic                            dacPowerDown,
    output logic                            pllPowerDown,
    output logic                            biasPowerDown,
    output logic                            clockPowerDown,
    output logic                            auxAccClear,
    output logic                            phaseAccClear,
    output logic                            sineSelect,
    output logic                            sweepRateTick
);
    logic [dcf_pkg::DATA_W-1:0] ctrlShadow;
    logic [dcf_pkg::DATA_W-1:0] ctrlActive;
    logic [dcf_pkg::RATE_W-1:0] rateShadow;
    logic [dcf_pkg::RATE_W-1:0] rateActive;
    logic [dcf_pkg::RATE_W-1:0] rateToTimer;
    logic [1:0]                 updateSync;
    logic                       updateLast;
    logic [1:0]                 pdSync;
    logic                       updatePulse;
    logic                       rateLoadNow;
    logic                       sweepOn;
    logic                       directOn;
    logic                       modulusOn;
    logic                       pinDown;
    logic                       fullDown;
    logic                       timerRunning;
    logic                       timerTick;
    logic [1:0]                 destSel;

    // sweep runs only with the aux accumulator on and no other mode owning it
    function automatic logic sweep_mode(input logic [31:0] cfg);
        sweep_mode = cfg[dcf_pkg::AUX_EN_BIT] && !cfg[dcf_pkg::MODULUS_BIT]
                     && !cfg[dcf_pkg::DIRECT_BIT];
    endfunction

    function automatic logic dest_is(input logic [1:0] dest, input logic [1:0] code);
        dest_is = (dest == code);
    endfunction

    // pins from outside pass two flip-flops before any use
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            updateSync <= 2'h0;
            updateLast <= 1'b0;
            pdSync     <= 2'h0;
        end
        else
        begin
            updateSync <= {updateSync[0], ioUpdatePin};
            updateLast <= updateSync[1];
            pdSync     <= {pdSync[0], powerDownPin};
        end
    end

    assign updatePulse = updateSync[1] && !updateLast;
    assign pinDown     = pdSync[1];
    assign fullDown    = pinDown && ctrlActive[dcf_pkg::EXT_PD_MODE_BIT];

    // host writes land in the shadow copies
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrlShadow <= dcf_pkg::CTRL_RESET;
            rateShadow <= dcf_pkg::RATE_RESET;
        end
        else if (hostWrite)
        begin
            if (hostAddr == dcf_pkg::CTRL_ADDR)
            begin
                ctrlShadow <= hostWriteData;
            end
            if (hostAddr == dcf_pkg::RATE_ADDR)
            begin
                rateShadow <= hostWriteData[dcf_pkg::RATE_W-1:0];
            end
        end
    end

    // shadow reaches the live copy only on the update strobe
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrlActive <= dcf_pkg::CTRL_RESET;
            rateActive <= dcf_pkg::RATE_RESET;
        end
        else if (updatePulse)
        begin
            ctrlActive <= ctrlShadow;
            rateActive <= rateShadow;
        end
    end

    // readback: shadow words and live status
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hostReadData <= '0;
        end
        else
        begin
            unique case (hostAddr)
                dcf_pkg::CTRL_ADDR:   hostReadData <= ctrlShadow;
                dcf_pkg::RATE_ADDR:   hostReadData <= {16'h0000, rateShadow};
                dcf_pkg::STATUS_ADDR: hostReadData <= {29'h0000_0000, fullDown,
                                                       pinDown, timerRunning};
                default:              hostReadData <= '0;
            endcase
        end
    end

    assign destSel   = ctrlActive[dcf_pkg::DEST_HI:dcf_pkg::DEST_LO];
    assign sweepOn   = sweep_mode(ctrlActive);
    assign directOn  = ctrlActive[dcf_pkg::DIRECT_BIT];
    assign modulusOn = ctrlActive[dcf_pkg::AUX_EN_BIT]
                       && ctrlActive[dcf_pkg::MODULUS_BIT];

    // immediate reload only when the setting being transferred asks for it
    assign rateLoadNow = updatePulse && ctrlShadow[dcf_pkg::RATE_RELOAD_BIT]
                         && sweep_mode(ctrlShadow);

    // an immediate reload must start from the rate arriving now, not the old one
    assign rateToTimer = rateLoadNow ? rateShadow : rateActive;

    // routing of the aux accumulator to the sweep outputs
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            freqSweep     <= 1'b0;
            phaseSweep    <= 1'b0;
            auxAccActive  <= 1'b0;
        end
        else
        begin
            freqSweep     <= sweepOn && dest_is(destSel, dcf_pkg::DEST_FREQ);
            phaseSweep    <= sweepOn && dest_is(destSel, dcf_pkg::DEST_PHASE);
            auxAccActive  <= ctrlActive[dcf_pkg::AUX_EN_BIT];
        end
    end

    // keying and modulus use of the aux accumulator
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            freqKeying    <= 1'b0;
            phaseKeying   <= 1'b0;
            modulusActive <= 1'b0;
        end
        else
        begin
            freqKeying    <= directOn && dest_is(destSel, dcf_pkg::DEST_FREQ);
            phaseKeying   <= directOn && dest_is(destSel, dcf_pkg::DEST_PHASE);
            // modulus relies on the host keeping destination at zero
            modulusActive <= modulusOn && dest_is(destSel, dcf_pkg::DEST_FREQ);
        end
    end

    // sweep behaviour and waveform selection
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dcOutputForce     <= 1'b0;
            waveformEnable    <= 1'b0;
            sweepLevelTrigger <= 1'b0;
            sweepNoDwell      <= 1'b0;
        end
        else
        begin
            dcOutputForce     <= sweepOn && ctrlActive[dcf_pkg::DC_OUT_BIT];
            waveformEnable    <= !(sweepOn && ctrlActive[dcf_pkg::DC_OUT_BIT])
                                 && !ctrlActive[dcf_pkg::DIG_PD_BIT]
                                 && !pinDown;
            sweepLevelTrigger <= ctrlActive[dcf_pkg::TRIG_BIT];
            sweepNoDwell      <= sweepOn && ctrlActive[dcf_pkg::NO_DWELL_BIT];
        end
    end

    // angle-to-amplitude function selection
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sineSelect <= 1'b0;
        end
        else
        begin
            sineSelect <= ctrlActive[dcf_pkg::SINE_BIT];
        end
    end

    // power-down selections from bits and the external pin
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            digitalPowerDown    <= 1'b0;
            dacDigitalPowerDown <= 1'b0;
            dacPowerDown        <= 1'b0;
            pllPowerDown        <= 1'b0;
            biasPowerDown       <= 1'b0;
            clockPowerDown      <= 1'b0;
        end
        else
        begin
            digitalPowerDown    <= ctrlActive[dcf_pkg::DIG_PD_BIT] || pinDown;
            dacDigitalPowerDown <= pinDown;
            dacPowerDown        <= ctrlActive[dcf_pkg::DAC_PD_BIT] || fullDown;
            pllPowerDown        <= fullDown;
            biasPowerDown       <= fullDown;
            clockPowerDown      <= ctrlActive[dcf_pkg::CLK_PD_BIT] || fullDown;
        end
    end

    // one-cycle aux accumulator clear on each update strobe with the aux clear bit set in the shadow
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            auxAccClear <= 1'b0;
        end
        else
        begin
            auxAccClear <= updatePulse && ctrlShadow[dcf_pkg::AUX_CLR_BIT];
        end
    end

    // one-cycle phase accumulator clear on each update strobe with the phase clear bit set in the shadow
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            phaseAccClear <= 1'b0;
        end
        else
        begin
            phaseAccClear <= updatePulse && ctrlShadow[dcf_pkg::PHASE_CLR_BIT];
        end
    end

    dcf_rate_timer dcf_rate_timer_inst
    (
        .clk          (clk),
        .reset_n      (reset_n),
        .runEnable    (sweepOn),
        .rateValue    (rateToTimer),
        .rateLoadNow  (rateLoadNow),
        .timerTick    (timerTick),
        .timerRunning (timerRunning)
    );

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sweepRateTick <= 1'b0;
        end
        else
        begin
            sweepRateTick <= timerTick;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/dcf_control_properties.sv */
// port assertions for the control function register bank
`timescale 1ns/10ps
`default_nettype none
module dcf_control_properties
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ioUpdatePin,
    input wire logic powerDownPin,
    input wire logic freqSweep,
    input wire logic phaseSweep,
    input wire logic freqKeying,
    input wire logic modulusActive,
    input wire logic auxAccActive,
    input wire logic dcOutputForce,
    input wire logic waveformEnable,
    input wire logic sweepNoDwell,
    input wire logic digitalPowerDown,
    input wire logic dacDigitalPowerDown,
    input wire logic dacPowerDown,
    input wire logic pllPowerDown,
    input wire logic biasPowerDown,
    input wire logic clockPowerDown,
    input wire logic auxAccClear,
    input wire logic phaseAccClear,
    input wire logic sineSelect
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // pin rise seen while the fast power-down output is still low
    sequence sPdRise;
        $rose(powerDownPin) ##0 !dacDigitalPowerDown;
    endsequence
    sequence sPdFollow;
        ##2 !dacDigitalPowerDown ##1 dacDigitalPowerDown;
    endsequence
    AST_SWEEP_EXCL: assert property (!(freqSweep && phaseSweep))
        else $error("both sweep destinations active");
    AST_SWEEP_AUX: assert property ((freqSweep || phaseSweep || sweepNoDwell) |-> auxAccActive)
        else $error("sweep output without aux enable");
    AST_DC_FORCE: assert property (dcOutputForce |-> auxAccActive && !waveformEnable)
        else $error("dc force with waveform or without sweep");
    AST_MODULUS: assert property (modulusActive |-> auxAccActive && !freqSweep && !phaseSweep)
        else $error("modulus mode with sweep output");
    AST_KEYING: assert property (freqKeying |-> !freqSweep && !phaseSweep)
        else $error("keying mode with sweep output");
    AST_FULL_PD: assert property (pllPowerDown |-> biasPowerDown && dacPowerDown && clockPowerDown && digitalPowerDown)
        else $error("full power-down incomplete");
    AST_FAST_PD: assert property (sPdRise |-> sPdFollow)
        else $error("pin power-down timing wrong");
    AST_AUX_CLR: assert property (auxAccClear |-> $past(ioUpdatePin, 3) ##1 !auxAccClear)
        else $error("aux clear not a single update pulse");
    AST_PH_CLR: assert property (phaseAccClear |-> $past(ioUpdatePin, 3) ##1 !phaseAccClear)
        else $error("phase clear not a single update pulse");
    AST_SINE_UPD: assert property ($changed(sineSelect) |-> $past(ioUpdatePin, 4))
        else $error("sine select changed without update");
endmodule
bind dcf_control dcf_control_properties dcf_control_properties_inst (.*);
`default_nettype wire

/* File: testbench/dcf_host_model.sv */
// host model: register writes, readback, update strobe and power-down pin
`timescale 1ns/10ps
`default_nettype none
module dcf_host_model
(
    input  wire logic        clk,
    input  wire logic [31:0] hostReadData,
    input  wire logic        auxAccClear,
    input  wire logic        phaseAccClear,
    output logic             hostWrite,
    output logic [7:0]       hostAddr,
    output logic [31:0]      hostWriteData,
    output logic             ioUpdatePin,
    output logic             powerDownPin
);
    initial
    begin
        hostWrite = 1'b0;
        hostAddr = 8'h00;
        hostWriteData = 32'h0000_0000;
        ioUpdatePin = 1'b0;
        powerDownPin = 1'b0;
    end
    task automatic write_word(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk);
        hostWrite = 1'b1;
        hostAddr = a;
        hostWriteData = d;
        @(negedge clk);
        hostWrite = 1'b0;
        hostWriteData = ~d;
    endtask
    task automatic read_word(input logic [7:0] a, output logic [31:0] d);
        @(negedge clk);
        hostAddr = a;
        @(negedge clk);
        d = hostReadData;
    endtask
    // high two clocks, low at least three, counting clear pulses meanwhile
    task automatic pulse_update(output int na, output int np);
        na = 0;
        np = 0;
        @(negedge clk);
        ioUpdatePin = 1'b1;
        for (int i = 1; i <= 5; i++)
        begin
            @(negedge clk);
            if (i == 2)
                ioUpdatePin = 1'b0;
            na += int'(auxAccClear);
            np += int'(phaseAccClear);
        end
    endtask
    task automatic set_pin(input logic v);
        @(negedge clk);
        powerDownPin = v;
        repeat (4) @(negedge clk);
    endtask
endmodule
`default_nettype wire

/* File: testbench/dds_control_function_low_bits_bench.sv */
// self-checking bench for the control function register bank
`timescale 1ns/10ps
`default_nettype none
module dds_control_function_low_bits_bench;
    logic        clk;
    logic        reset_n;
    logic        hostWrite;
    logic [7:0]  hostAddr;
    logic [31:0] hostWriteData;
    logic [31:0] hostReadData;
    logic        ioUpdatePin;
    logic        powerDownPin;
    logic        freqSweep, phaseSweep, freqKeying, phaseKeying, modulusActive;
    logic        auxAccActive, dcOutputForce, waveformEnable, sweepLevelTrigger;
    logic        sweepNoDwell, digitalPowerDown, dacDigitalPowerDown, dacPowerDown;
    logic        pllPowerDown, biasPowerDown, clockPowerDown, auxAccClear;
    logic        phaseAccClear, sineSelect, sweepRateTick;
    logic [31:0] rd;
    int          n_errors = 0;
    int          total_checks = 0;
    int          nA, nP, w;
    dcf_control dcf_control_inst (.*);
    dcf_host_model host_inst (.*);
    initial clk = 1'b0;
    always #5 clk = ~clk;
    function automatic logic [31:0] b(input int n);
        return 32'h0000_0001 << n;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic ctl(input logic [31:0] d);
        host_inst.write_word(dcf_pkg::CTRL_ADDR, d);
        host_inst.pulse_update(nA, nP);
    endtask
    // counts falling edges until the next ramp tick
    task automatic wait_tick(output int n);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (sweepRateTick !== 1'b1 && n < 100);
        check(sweepRateTick, 1'b1);
    endtask
    task automatic t_regs();
        host_inst.read_word(dcf_pkg::CTRL_ADDR, rd);
        check(rd, dcf_pkg::CTRL_RESET);
        host_inst.write_word(8'h05, 32'hFFFF_FFFF);
        host_inst.read_word(8'h05, rd);
        check(rd, 32'h0000_0000);
        host_inst.write_word(dcf_pkg::CTRL_ADDR, b(dcf_pkg::SINE_BIT));
        host_inst.read_word(dcf_pkg::CTRL_ADDR, rd);
        check(rd, 32'h0000_0001);
        check(sineSelect, 1'b0);
        host_inst.pulse_update(nA, nP);
        check(sineSelect, 1'b1);
        ctl(32'h0000_0000);
        check(sineSelect, 1'b0);
    endtask
    task automatic t_sweep();
        for (int d = 0; d < 2; d++)
        begin
            ctl(b(11) | b(10) | b(9) | b(8) | (d << 12));
            check(freqSweep, d == 0);
            check(phaseSweep, d == 1);
            check(auxAccActive, 1'b1);
            check(dcOutputForce, 1'b1);
            check(waveformEnable, 1'b0);
            check(sweepLevelTrigger, 1'b1);
            check(sweepNoDwell, 1'b1);
        end
        ctl(b(10) | b(8));
        check(auxAccActive, 1'b0);
        check(dcOutputForce, 1'b0);
        check(waveformEnable, 1'b1);
        check(sweepLevelTrigger, 1'b0);
        check(sweepNoDwell, 1'b0);
    endtask
    task automatic t_modes();
        ctl(b(16));
        check(freqKeying, 1'b1);
        ctl(b(16) | b(12));
        check(phaseKeying, 1'b1);
        ctl(b(28) | b(11));
        check(modulusActive, 1'b1);
        check(freqSweep, 1'b0);
    endtask
    task automatic t_power();
        ctl(b(6) | b(5) | b(4));
        check(digitalPowerDown, 1'b1);
        check(dacPowerDown, 1'b1);
        check(clockPowerDown, 1'b1);
        ctl(32'h0000_0000);
        host_inst.set_pin(1'b1);
        check({digitalPowerDown, dacDigitalPowerDown, pllPowerDown, clockPowerDown}, 4'hC);
        host_inst.set_pin(1'b0);
        ctl(b(7));
        host_inst.set_pin(1'b1);
        check({pllPowerDown, biasPowerDown, dacPowerDown, clockPowerDown}, 4'hF);
        host_inst.read_word(dcf_pkg::STATUS_ADDR, rd);
        check(rd, 32'h0000_0006);
        host_inst.set_pin(1'b0);
        check(pllPowerDown, 1'b0);
    endtask
    task automatic t_clear();
        ctl(b(2) | b(1));
        check(nA, 1);
        check(nP, 1);
        host_inst.pulse_update(nA, nP);
        check(nA, 1);
        ctl(32'h0000_0000);
        check(nA + nP, 0);
    endtask
    task automatic t_rate();
        host_inst.write_word(dcf_pkg::RATE_ADDR, 32'd40);
        ctl(b(11));
        wait_tick(w);
        wait_tick(w);
        check(w, 41);
        host_inst.write_word(dcf_pkg::RATE_ADDR, 32'd2);
        ctl(b(11));
        wait_tick(w);
        check(w > 20, 1'b1);
        wait_tick(w);
        check(w, 3);
        host_inst.write_word(dcf_pkg::RATE_ADDR, 32'd40);
        ctl(b(11) | b(3));
        wait_tick(w);
        host_inst.write_word(dcf_pkg::RATE_ADDR, 32'd2);
        ctl(b(11) | b(3));
        wait_tick(w);
        check(w, 2);
        host_inst.read_word(dcf_pkg::STATUS_ADDR, rd);
        check(rd, 32'h0000_0001);
    endtask
    initial
    begin
        reset_n = 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        t_regs();
        t_sweep();
        t_modes();
        t_power();
        t_clear();
        t_rate();
        end_sim();
    end
    initial
    begin
        #200000;
        n_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
